// [pkg/lid_pkg.sv]
// constants and types for the indicator output driver
package lid_pkg;

	// ****************************************
	// reference clock
	// ****************************************
	localparam int unsigned REF_CLK_MII_MHZ  = 25;
	localparam int unsigned REF_CLK_RMII_MHZ = 50;

	// ****************************************
	// sizes and reset values
	// ****************************************
	localparam int unsigned IND_COUNT   = 4;
	localparam int unsigned SET_COUNT   = 8;
	localparam logic [3:0]  IND_RST_VAL = 4'hf;
	localparam logic [2:0]  SEL_RST_VAL = 3'h0;
	localparam logic [2:0]  SYNC_RST_VAL  = 3'h0;
	localparam logic        STRAP_RST_VAL = 1'h0;

	// ****************************************
	// event sets
	// ****************************************
	typedef enum logic [2:0] {
		LID_SET_DEFAULT = 3'b000,
		LID_SET_ALT     = 3'b001,
		LID_SET_LINK    = 3'b010,
		LID_SET_TRAFFIC = 3'b011,
		LID_SET_SPEED   = 3'b100,
		LID_SET_FAULT   = 3'b101,
		LID_SET_LNKCOL  = 3'b110,
		LID_SET_MIXED   = 3'b111
	} lid_set_t;

endpackage : lid_pkg

// [hdl/lid_driver.sv]
// indicator output driver: event set selection, strap default, user outputs

module lid_driver
	import lid_pkg::*;
#(
	parameter int unsigned NUM_IND  = IND_COUNT,
	parameter int unsigned NUM_SETS = SET_COUNT
)
(
	input  wire logic               clk_sys_i,
	input  wire logic               nrst_i,
	input  wire logic               indicator_default_select_i,
	input  wire logic [2:0]         set_sel_i,
	input  wire logic               set_sel_wr_i,
	input  wire logic               user_mode_i,
	input  wire logic [NUM_IND-1:0] user_level_i,
	input  wire logic               link_i,
	input  wire logic               speed100_i,
	input  wire logic               full_duplex_i,
	input  wire logic               activity_i,
	input  wire logic               collision_i,
	input  wire logic               far_fault_i,
	output logic      [NUM_IND-1:0] indicator_outputs_o
);

	// ****************************************
	// parameter checks
	// ****************************************
	// the event sets are wired for four outputs and a three-bit set code
	if (NUM_IND != IND_COUNT) begin : g_chk_ind
		$error("lid_driver: NUM_IND must equal the four wired indicators");
	end
	if (NUM_SETS != SET_COUNT) begin : g_chk_sets
		$error("lid_driver: NUM_SETS must equal the eight decoded sets");
	end

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [2:0]         strap_sync;
		logic               strap;
		logic               sel_valid;
		lid_set_t           sel;
		logic [NUM_IND-1:0] out_n;
	} lid_state_t;

	lid_state_t         st_q;
	lid_state_t         st_d;
	logic [NUM_IND-1:0] ev;
	logic               link100;
	logic               link10;
	logic               link_act;
	logic               act_half;
	logic               act_full;
	logic               act_col;

	// ****************************************
	// event terms
	// ****************************************
	always_comb begin
		link100  = link_i & speed100_i;
		link10   = link_i & ~speed100_i;
		link_act = link_i | activity_i;
		act_half = activity_i & ~full_duplex_i;
		act_full = activity_i & full_duplex_i;
		act_col  = activity_i | collision_i;
	end

	// ****************************************
	// event selection
	// ****************************************
	// bit 3 is the highest indicator index; 1 means the event is present
	always_comb begin
		ev = '0;
		unique case (st_q.sel)
			LID_SET_DEFAULT: begin
				ev[3] = link100;
				ev[2] = activity_i;
				ev[1] = full_duplex_i;
				ev[0] = link10;
			end
			LID_SET_ALT: begin
				ev[3] = link_act;
				ev[2] = collision_i;
				ev[1] = full_duplex_i;
				ev[0] = speed100_i;
			end
			LID_SET_LINK: begin
				ev[3] = link_i;
				ev[2] = activity_i;
				ev[1] = collision_i;
				ev[0] = full_duplex_i;
			end
			LID_SET_TRAFFIC: begin
				ev[3] = activity_i;
				ev[2] = act_half;
				ev[1] = act_full;
				ev[0] = collision_i;
			end
			LID_SET_SPEED: begin
				ev[3] = link100;
				ev[2] = link10;
				ev[1] = activity_i;
				ev[0] = collision_i;
			end
			LID_SET_FAULT: begin
				ev[3] = link_i;
				ev[2] = activity_i;
				ev[1] = far_fault_i;
				ev[0] = collision_i;
			end
			LID_SET_LNKCOL: begin
				ev[3] = link_act;
				ev[2] = collision_i;
				ev[1] = speed100_i;
				ev[0] = far_fault_i;
			end
			LID_SET_MIXED: begin
				ev[3] = link_i;
				ev[2] = full_duplex_i;
				ev[1] = speed100_i;
				ev[0] = act_col;
			end
		endcase
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		// strap pin: three flops, level taken once the last two agree
		st_d.strap_sync = {st_q.strap_sync[1:0], indicator_default_select_i};
		if (st_q.strap_sync[2] == st_q.strap_sync[1]) begin
			st_d.strap = st_q.strap_sync[1];
		end
		// a write overrides the strap default until the next reset
		if (set_sel_wr_i) begin
			st_d.sel       = lid_set_t'(set_sel_i);
			st_d.sel_valid = 1'h1;
		end else if (!st_q.sel_valid && st_d.strap) begin
			st_d.sel = LID_SET_ALT;
		end else if (!st_q.sel_valid) begin
			st_d.sel = LID_SET_DEFAULT;
		end
		// registered so a selection change cannot glitch the pins
		if (user_mode_i) begin
			st_d.out_n = ~user_level_i;
		end else begin
			st_d.out_n = ~ev;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			st_q.strap_sync <= SYNC_RST_VAL;
			st_q.strap      <= STRAP_RST_VAL;
			st_q.sel_valid  <= 1'h0;
			st_q.sel        <= lid_set_t'(SEL_RST_VAL);
			st_q.out_n      <= IND_RST_VAL;
		end else begin
			st_q <= st_d;
		end
	end

	// the pins come straight from the output flops
	assign indicator_outputs_o = st_q.out_n;

	// ****************************************
	// checks
	// ****************************************
	// all on the reference clock; reset masks every check but the dark one
	AST_RESET_DARK: assert property (@(posedge clk_sys_i)
		!nrst_i |=> indicator_outputs_o == IND_RST_VAL)
		else $error("outputs not dark after reset");

	AST_ACTIVE_LOW: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		user_mode_i |=> indicator_outputs_o == ~$past(user_level_i))
		else $error("user level not inverted");

	AST_SEL_WRITE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		set_sel_wr_i |=> st_q.sel == $past(set_sel_i))
		else $error("set select not taken");

	AST_SEL_HOLD: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(st_q.sel_valid && !set_sel_wr_i) |=> st_q.sel == $past(st_q.sel))
		else $error("written set select moved");

	AST_DEF_LOW: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(!st_q.sel_valid && !set_sel_wr_i && !st_d.strap) |=> st_q.sel == LID_SET_DEFAULT)
		else $error("strap low default wrong");

	AST_DEF_HIGH: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(!st_q.sel_valid && !set_sel_wr_i && st_d.strap) |=> st_q.sel == LID_SET_ALT)
		else $error("strap high default wrong");

	// the strap level may only move once the second and third flops agree
	AST_STRAP_AGREE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		($past(nrst_i) && $changed(st_q.strap)) |->
			($past(st_q.strap_sync[2]) == $past(st_q.strap_sync[1])))
		else $error("strap taken before sync flops agreed");

	AST_USER_OUT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		user_mode_i ##1 (user_mode_i && $stable(user_level_i)) |=> $stable(indicator_outputs_o))
		else $error("user output moved");

	AST_EVENT_OUT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		!user_mode_i |=> indicator_outputs_o == ~$past(ev))
		else $error("event output mismatch");

endmodule // lid_driver

// [tb/lid_led_model.sv]
// lamp model standing on the indicator outputs
module lid_led_model (
	input  wire logic [3:0] indicator_outputs_i,
	output logic      [3:0] lit_o
);
	timeunit 1ns;
	timeprecision 1ns;
	assign lit_o = ~indicator_outputs_i;
endmodule // lid_led_model

// [tb/lid_driver_tb_top.sv]
// testbench for the indicator output driver
module lid_driver_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_sys_i = 0, nrst_i = 0, strap = 0, wr = 0, um = 0;
	logic [2:0] sel = 3'h0;
	logic [3:0] ulv = 4'h0, lit, outs;
	logic       lnk = 1, s100 = 1, fdx = 1, act = 0, col = 0, flt = 0;
	int         error_cnt = 0, check_count = 0;
	always #20 clk_sys_i = ~clk_sys_i;
	lid_driver u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.indicator_default_select_i(strap), .set_sel_i(sel), .set_sel_wr_i(wr),
		.user_mode_i(um), .user_level_i(ulv), .link_i(lnk), .speed100_i(s100),
		.full_duplex_i(fdx), .activity_i(act), .collision_i(col),
		.far_fault_i(flt), .indicator_outputs_o(outs));
	lid_led_model u_led (.indicator_outputs_i(outs), .lit_o(lit));
	task chk(input logic [3:0] exp);
		check_count++;
		if (lit !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: lit %h exp %h", $time, lit, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task close_out;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// reset with a given strap level, lamps dark while held
	task rst(input logic s);
		strap = s;
		nrst_i = 0;
		cyc(8);
		chk(4'h0);
		nrst_i = 1;
		cyc(8);
	endtask
	task sc_strap_low;
		rst(1'b0);
		chk(4'ha);
	endtask
	task sc_strap_high;
		rst(1'b1);
		chk(4'hb);
	endtask
	// back-to-back writes, last one wins; the strap no longer matters
	task sc_sets;
		rst(1'b0);
		wr = 1;
		sel = 3'h2;
		cyc(1);
		sel = 3'h4;
		cyc(1);
		wr = 0;
		cyc(2);
		chk(4'h8);
		strap = 1;
		cyc(8);
		chk(4'h8);
	endtask
	task sc_user;
		um = 1;
		ulv = 4'ha;
		cyc(1);
		chk(4'ha);
		ulv = 4'h5;
		cyc(1);
		chk(4'h5);
		cyc(2);
		chk(4'h5);
		um = 0;
		cyc(1);
		chk(4'ha);
	endtask
	// every set code, two input patterns each
	task sc_all_sets;
		logic [3:0] exp_a [8] = '{4'h5, 4'hc, 4'he, 4'hd, 4'h7, 4'hf, 4'hd, 4'h9};
		logic [3:0] exp_b [8] = '{4'h2, 4'h3, 4'h1, 4'h0, 4'h0, 4'h0, 4'h2, 4'h6};
		for (int i = 0; i < 8; i++) begin
			{lnk, s100, fdx, act, col, flt} = 6'h27;
			wr = 1;
			sel = 3'(i);
			cyc(1);
			wr = 0;
			cyc(1);
			chk(exp_a[i]);
			{lnk, s100, fdx, act, col, flt} = 6'h18;
			cyc(1);
			chk(exp_b[i]);
		end
	endtask
	initial begin
		sc_strap_high();
		sc_strap_low();
		sc_user();
		sc_sets();
		sc_all_sets();
		close_out();
	end
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
endmodule // lid_driver_tb_top
